/* File: hw/sar_readout.sv */
// Conversion and serial readout sequencing of the converter, device side.
// Assumes results arrive from the analog core as words; select and shift clock are pins.
//
// How it works
// - A falling select starts sampling, conversion and the transfer.
// - The first one and a half to two shift periods acquire the input.
// - On the second falling shift edge the output drives a low null bit.
// - Then the N result bits follow, most significant first.
// - After the last bit, select rising puts the output in high impedance.
// - A new conversion needs select high then low; low never retriggers.
// - Results are unsigned straight binary, zero gives all zeros.
// - Twelve-bit ideal codes FFF, 800, 7FF and 000 pass through unchanged.
// - Power-down is entered after conversion and whenever select is high.
// - Select high stops digital logic fully; clocking after completion keeps it active.
// - The output changes on falling shift clock edges only.
// - Further clocks repeat result bits 1 to N-1 LSB first, then zeros forever.
// - The result is the oldest FIFO word at the null bit edge, or all zeros if the FIFO is empty.
`timescale 1ns/1ps
`default_nettype none
module sar_readout #(
  parameter int unsigned RES_BITS   = sar_pkg::RES_BITS_12,
  parameter int unsigned FIFO_DEPTH = sar_pkg::FIFO_DEPTH_DFLT
) (
  input  wire logic                mclk,          // System clock, 250 MHz.
  input  wire logic                rst_n,         // Synchronous reset, active low.
  input  wire logic                sel_n_pin,     // Convert select pin, active low.
  input  wire logic                shift_clk_pin, // Serial shift clock pin.
  output logic                     dout_o,        // Serial data out.
  output logic                     dout_oe,       // Serial data drive enable.
  output logic                     sample_req,    // Pulse: analog core samples now.
  input  wire logic [RES_BITS-1:0] res_data,      // Result word from the analog core.
  input  wire logic                res_valid,     // Result word offered.
  output logic                     res_ready,     // FIFO has room.
  output logic                     analog_on,     // Analog section powered.
  output logic                     digital_on     // Digital section active.
);
  initial begin
    if (RES_BITS != sar_pkg::RES_BITS_12 && RES_BITS != sar_pkg::RES_BITS_10 &&
        RES_BITS != sar_pkg::RES_BITS_8) begin
      $error("sar_readout supports 12, 10 or 8 result bits only");
    end
  end
  typedef struct packed {
    logic [2:0]          sel_sync;
    logic [2:0]          clk_sync;
    logic                sel_n;
    logic                sclk;
    sar_pkg::sar_phase_t phase;
    logic [1:0]          acq;
    logic [3:0]          bitcnt;
    logic [RES_BITS-1:0] word;
    logic                dout;
    logic                oe;
    logic                samp;
  } sar_st_t;
  sar_st_t st_ff;
  sar_st_t nxt_st;
  logic [RES_BITS-1:0] fifo_data;
  logic                fifo_valid;
  logic                fifo_pop;
  logic                sel_fall;
  logic                sclk_fall;
  sar_fifo #(
    .WIDTH (RES_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_data   (res_data),
    .in_valid  (res_valid),
    .in_ready  (res_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );
  // A level counts once the second and third stages agree.
  function automatic logic agreed(input logic [2:0] s, input logic old);
    agreed = (s[1] == s[2]) ? s[2] : old;
  endfunction
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.sel_sync = {st_ff.sel_sync[1:0], sel_n_pin};
    nxt_st.clk_sync = {st_ff.clk_sync[1:0], shift_clk_pin};
    nxt_st.sel_n    = agreed(st_ff.sel_sync, st_ff.sel_n);
    nxt_st.sclk     = agreed(st_ff.clk_sync, st_ff.sclk);
    nxt_st.samp     = 1'b0;
    sel_fall        = st_ff.sel_n && !nxt_st.sel_n;
    sclk_fall       = st_ff.sclk && !nxt_st.sclk;
    fifo_pop        = 1'b0;
    if (nxt_st.sel_n) begin
      nxt_st.phase  = sar_pkg::SAR_IDLE;
      nxt_st.oe     = 1'b0;
      nxt_st.dout   = 1'b0;
      nxt_st.acq    = sar_pkg::ACQ_RST;
      nxt_st.bitcnt = sar_pkg::BITCNT_RST;
    end else if (sel_fall && st_ff.phase == sar_pkg::SAR_IDLE) begin
      nxt_st.phase = sar_pkg::SAR_ACQUIRE;
      nxt_st.samp  = 1'b1;
      nxt_st.acq   = sar_pkg::ACQ_RST;
    end else if (sclk_fall) begin
      case (st_ff.phase)
        sar_pkg::SAR_ACQUIRE: begin
          nxt_st.acq = st_ff.acq + 2'h1;
          if (st_ff.acq == 2'(sar_pkg::ACQUIRE_EDGES - 1)) begin
            nxt_st.phase = sar_pkg::SAR_NULL;
            nxt_st.oe    = 1'b1;
            nxt_st.dout  = 1'b0;
            nxt_st.word  = fifo_valid ? fifo_data : '0;
            fifo_pop     = fifo_valid;
          end
        end
        sar_pkg::SAR_NULL: begin
          nxt_st.phase  = sar_pkg::SAR_MSB;
          nxt_st.dout   = st_ff.word[RES_BITS-1];
          nxt_st.bitcnt = 4'h1;
        end
        sar_pkg::SAR_MSB: begin
          if (st_ff.bitcnt == 4'(RES_BITS)) begin
            // The LSB is already out; continue LSB first from bit 1 when clocking continues.
            nxt_st.phase  = sar_pkg::SAR_LSB;
            nxt_st.dout   = st_ff.word[1];
            nxt_st.bitcnt = 4'h2;
          end else begin
            nxt_st.dout   = st_ff.word[4'(RES_BITS-1) - st_ff.bitcnt];
            nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
          end
        end
        sar_pkg::SAR_LSB: begin
          if (st_ff.bitcnt == 4'(RES_BITS)) begin
            nxt_st.phase = sar_pkg::SAR_ZERO;
            nxt_st.dout  = 1'b0;
          end else begin
            nxt_st.dout   = st_ff.word[st_ff.bitcnt];
            nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
          end
        end
        sar_pkg::SAR_ZERO: begin
          nxt_st.dout = 1'b0;
        end
        default: begin
          nxt_st.phase = st_ff.phase;
        end
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff          <= '0;
      st_ff.sel_sync <= 3'h7;
      st_ff.sel_n    <= 1'b1;
      st_ff.phase    <= sar_pkg::SAR_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign dout_o     = st_ff.dout;
  assign dout_oe    = st_ff.oe;
  assign sample_req = st_ff.samp;
  // Analog runs only from select falling until the last result bit.
  assign analog_on  = st_ff.phase == sar_pkg::SAR_ACQUIRE ||
                      st_ff.phase == sar_pkg::SAR_NULL ||
                      st_ff.phase == sar_pkg::SAR_MSB;
  assign digital_on = !st_ff.sel_n;

  AST_OE_OFF_SEL: assert property (@(posedge mclk) disable iff (!rst_n)
    st_ff.sel_n |=> !dout_oe) else $error("output driven while select high");
  AST_NULL_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(dout_oe) |-> !dout_o && st_ff.phase == sar_pkg::SAR_NULL)
    else $error("null bit not low");
  AST_START: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(sample_req) |-> st_ff.phase == sar_pkg::SAR_ACQUIRE && !st_ff.sel_n)
    else $error("sampling without select low");
  AST_NO_RETRIG: assert property (@(posedge mclk) disable iff (!rst_n)
    sample_req |=> !sample_req) else $error("conversion retriggered");
  AST_EDGE_ONLY: assert property (@(posedge mclk) disable iff (!rst_n)
    ($changed(dout_o) && !st_ff.sel_n && !$past(st_ff.sel_n)) |->
    $past(st_ff.sclk && !nxt_st.sclk)) else $error("data changed off falling edge");
  AST_ACQ_LEN: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(dout_oe) |-> $past(st_ff.acq) == 2'(sar_pkg::ACQUIRE_EDGES - 1))
    else $error("acquire span wrong");
  AST_MSB_FIRST: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_ff.phase == sar_pkg::SAR_MSB && st_ff.bitcnt == 4'h1) |->
    dout_o == st_ff.word[RES_BITS-1]) else $error("first bit not MSB");
  AST_ZERO_TAIL: assert property (@(posedge mclk) disable iff (!rst_n)
    st_ff.phase == sar_pkg::SAR_ZERO |-> !dout_o) else $error("tail not zero");
  AST_POWER: assert property (@(posedge mclk) disable iff (!rst_n)
    st_ff.sel_n |-> !analog_on && !digital_on) else $error("powered while select high");

  // A synced shift clock fall that lands while select stays low.
  sequence seq_shift_low;
    sclk_fall && !nxt_st.sel_n;
  endsequence

  // A clock with no shift fall while select stays low.
  sequence seq_quiet_low;
    !sclk_fall && !nxt_st.sel_n;
  endsequence

  // A select fall accepted while idle.
  sequence seq_start;
    st_ff.sel_n && !nxt_st.sel_n && st_ff.phase == sar_pkg::SAR_IDLE;
  endsequence

  AST_SAMPLE_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_start |=> sample_req && st_ff.phase == sar_pkg::SAR_ACQUIRE)
    else $error("select fall did not start a conversion");

  AST_RETRIG_PAST: assert property (@(posedge mclk) disable iff (!rst_n)
    sample_req |-> !st_ff.sel_n && $past(st_ff.sel_n))
    else $error("sampling without a fresh select fall");

  AST_DROP_CLEARS: assert property (@(posedge mclk) disable iff (!rst_n)
    nxt_st.sel_n |=> st_ff.bitcnt == sar_pkg::BITCNT_RST && st_ff.acq == sar_pkg::ACQ_RST)
    else $error("select high left counters running");

  AST_ACQ_STEP: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_ff.phase == sar_pkg::SAR_ACQUIRE &&
     st_ff.acq != 2'(sar_pkg::ACQUIRE_EDGES - 1)) ##0 seq_shift_low |=>
    st_ff.phase == sar_pkg::SAR_ACQUIRE && st_ff.acq == $past(st_ff.acq) + 2'h1)
    else $error("acquire count did not step");

  AST_ACQ_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_ff.phase == sar_pkg::SAR_ACQUIRE) ##0 seq_quiet_low |=>
    st_ff.phase == sar_pkg::SAR_ACQUIRE && !dout_oe)
    else $error("acquire left without a shift fall");

  AST_NULL_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_ff.phase == sar_pkg::SAR_NULL) ##0 seq_quiet_low |=>
    st_ff.phase == sar_pkg::SAR_NULL && dout_oe && !dout_o)
    else $error("null bit did not stand a full period");

  AST_OE_ON_FALL: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(dout_oe) |-> $past(sclk_fall))
    else $error("driver enabled off a shift fall");

  AST_NULL_NEXT: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_ff.phase == sar_pkg::SAR_NULL) ##0 seq_shift_low |=>
    st_ff.phase == sar_pkg::SAR_MSB && dout_o == st_ff.word[RES_BITS-1])
    else $error("msb did not follow the null bit");

  AST_MSB_STEP: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_ff.phase == sar_pkg::SAR_MSB && st_ff.bitcnt < 4'(RES_BITS)) ##0 seq_shift_low |=>
    dout_o == st_ff.word[4'(RES_BITS) - st_ff.bitcnt])
    else $error("result bit out of order");

  AST_BITCNT_RANGE: assert property (@(posedge mclk) disable iff (!rst_n)
    st_ff.bitcnt <= 4'(RES_BITS))
    else $error("bit counter past the result width");

  AST_OE_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    (dout_oe && !nxt_st.sel_n) |=> dout_oe)
    else $error("driver released while select low");

  AST_OE_DROP: assert property (@(posedge mclk) disable iff (!rst_n)
    (dout_oe && nxt_st.sel_n) |=> !dout_oe)
    else $error("driver kept after select rise");

  AST_HOLD_STABLE: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_quiet_low |=> $stable(dout_o))
    else $error("data moved without a shift fall");

  AST_LSB_REPEAT: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_ff.phase == sar_pkg::SAR_MSB && st_ff.bitcnt == 4'(RES_BITS)) ##0 seq_shift_low |=>
    st_ff.phase == sar_pkg::SAR_LSB && dout_o == st_ff.word[1])
    else $error("lsb-first repeat did not start");

  AST_LSB_STEP: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_ff.phase == sar_pkg::SAR_LSB && st_ff.bitcnt < 4'(RES_BITS)) ##0 seq_shift_low |=>
    dout_o == st_ff.word[st_ff.bitcnt - 4'h1])
    else $error("lsb-first bit out of order");

  AST_LSB_END: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_ff.phase == sar_pkg::SAR_LSB && st_ff.bitcnt == 4'(RES_BITS)) ##0 seq_shift_low |=>
    st_ff.phase == sar_pkg::SAR_ZERO && !dout_o)
    else $error("zeros did not follow the repeat");

  AST_ZERO_STAY: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_ff.phase == sar_pkg::SAR_ZERO && !nxt_st.sel_n) |=> st_ff.phase == sar_pkg::SAR_ZERO)
    else $error("zero tail left while select low");

  AST_ANALOG_STOP: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_ff.phase == sar_pkg::SAR_MSB && st_ff.bitcnt == 4'(RES_BITS)) ##0 seq_shift_low |=>
    !analog_on && digital_on)
    else $error("analog still on after completion");

  AST_SEL_IDLE: assert property (@(posedge mclk) disable iff (!rst_n)
    st_ff.sel_n |-> st_ff.phase == sar_pkg::SAR_IDLE && !dout_oe)
    else $error("logic active while select high");

  AST_POP_WHEN: assert property (@(posedge mclk) disable iff (!rst_n)
    fifo_pop |-> sclk_fall && st_ff.phase == sar_pkg::SAR_ACQUIRE)
    else $error("result taken outside the null bit edge");

  AST_POP_ONE: assert property (@(posedge mclk) disable iff (!rst_n)
    fifo_pop |=> !fifo_pop)
    else $error("two results taken for one conversion");

  AST_WORD_STABLE: assert property (@(posedge mclk) disable iff (!rst_n)
    st_ff.phase != sar_pkg::SAR_ACQUIRE |=> $stable(st_ff.word))
    else $error("result word changed during transfer");
endmodule // sar_readout
`default_nettype wire

/* File: hw/sar_pkg.sv */
// Package for the successive-approximation converter serial readout block.
// Assumes a single 250 MHz system clock mclk; the shift clock arrives as a pin.
package sar_pkg;
  localparam int unsigned MCLK_PERIOD_PS   = 4000;
  localparam int unsigned RES_BITS_12      = 12;
  localparam int unsigned RES_BITS_10      = 10;
  localparam int unsigned RES_BITS_8       = 8;
  localparam int unsigned SYNC_STAGES      = 3;
  localparam int unsigned FIFO_DEPTH_DFLT  = 8;
  // Shift clock periods spent acquiring before the null bit: 1.5 to 2.0.
  localparam int unsigned ACQUIRE_EDGES    = 2;
  localparam logic [3:0]  BITCNT_RST       = 4'h0;
  localparam logic [1:0]  ACQ_RST          = 2'h0;
  // Serial phases, Gray coded along the usual path.
  typedef enum logic [2:0] {
    SAR_IDLE    = 3'b000,
    SAR_ACQUIRE = 3'b001,
    SAR_NULL    = 3'b011,
    SAR_MSB     = 3'b010,
    SAR_LSB     = 3'b110,
    SAR_ZERO    = 3'b111
  } sar_phase_t;
endpackage : sar_pkg

/* File: hw/sar_fifo.sv */
// Small synchronous FIFO carrying conversion results into the readout logic.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sar_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             mclk,      // System clock.
  input  wire logic             rst_n,     // Synchronous reset, active low.
  input  wire logic [WIDTH-1:0] in_data,   // Word to store.
  input  wire logic             in_valid,  // Word offered.
  output logic                  in_ready,  // Room available.
  output logic      [WIDTH-1:0] out_data,  // Oldest word.
  output logic                  out_valid, // Word available.
  input  wire logic             out_ready  // Drain accepts.
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("sar_fifo needs a power-of-two depth of at least two");
    end
  end
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } sar_fifo_st_t;
  sar_fifo_st_t st_ff;
  sar_fifo_st_t nxt_st;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic push;
  logic pop;
  assign in_ready  = (st_ff.wr - st_ff.rd) != (AW+1)'(DEPTH);
  assign out_valid = st_ff.wr != st_ff.rd;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[st_ff.rd[AW-1:0]];
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.wr = st_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_st.rd = st_ff.rd + 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
    if (push) begin
      mem_ff[st_ff.wr[AW-1:0]] <= in_data;
    end
  end
endmodule // sar_fifo
`default_nettype wire

/* File: verification/sar_host_model.sv */
// Host model that drives convert select and the shift clock and samples the data line.
// Assumes the bench hands it the resolved data line and the analog power flag.
`timescale 1ns/1ps
`default_nettype none
module sar_host_model #(
  parameter int HALF = 8
) (
  input  wire logic mclk,      // System clock.
  output logic      sel_n,     // Convert select, active low.
  output logic      sclk,      // Shift clock, idle low.
  input  wire logic dout_line, // Resolved serial data line.
  input  wire logic analog_on  // Analog power flag, recorded for checks.
);
  logic got[$];
  logic ana[$];
  initial begin
    sel_n = 1'b1;
    sclk  = 1'b0;
  end
  // The clock stands still between frames, so no stray edge can hide a retrigger.
  task automatic frame(input int k);
    int i;
    got.delete();
    ana.delete();
    @(posedge mclk) sel_n <= 1'b0;
    repeat (HALF) @(posedge mclk);
    for (i = 0; i < k; i++) begin
      @(negedge mclk) begin
        got.push_back(dout_line);
        ana.push_back(analog_on);
      end
      @(posedge mclk) sclk <= 1'b1;
      repeat (HALF) @(posedge mclk);
      sclk <= 1'b0;
      repeat (HALF) @(posedge mclk);
    end
  endtask
  task automatic release_sel();
    @(posedge mclk) sel_n <= 1'b1;
    repeat (2 * HALF) @(posedge mclk);
  endtask
endmodule // sar_host_model
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the serial readout block, with a queue model of the results.
// Assumes the package, the design files and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("Error %0t got %h expected %h", $time, (a), (b)); end end
module testbench;
  localparam int N = 12;
  logic         mclk      = 1'b0;
  logic         rst_n     = 1'b0;
  logic [N-1:0] res_data  = '0;
  logic         res_valid = 1'b0;
  wire          sel_n, sclk, dout_o, dout_oe, sample_req, res_ready, analog_on, digital_on;
  wire          dout_line = dout_oe ? dout_o : 1'bz;
  int           miscompares = 0;
  int           n_checks    = 0;
  int           n_samp      = 0;
  int           cyc         = 0;
  logic [N-1:0] q[$];
  logic [N-1:0] codes[4] = '{12'hfff, 12'h800, 12'h7ff, 12'h000};
  always #2 mclk = ~mclk;
  sar_readout #(.RES_BITS(N), .FIFO_DEPTH(8)) dut (.mclk(mclk), .rst_n(rst_n),
    .sel_n_pin(sel_n), .shift_clk_pin(sclk), .dout_o(dout_o), .dout_oe(dout_oe),
    .sample_req(sample_req), .res_data(res_data), .res_valid(res_valid),
    .res_ready(res_ready), .analog_on(analog_on), .digital_on(digital_on));
  sar_host_model #(.HALF(8)) host (.mclk(mclk), .sel_n(sel_n), .sclk(sclk),
    .dout_line(dout_line), .analog_on(analog_on));
  always @(posedge mclk) if (sample_req === 1'b1) n_samp <= n_samp + 1;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic push(input logic [N-1:0] w);
    @(posedge mclk) begin
      res_data  <= w;
      res_valid <= 1'b1;
    end
    @(negedge mclk) if (res_ready === 1'b1) q.push_back(w);
    @(posedge mclk) res_valid <= 1'b0;
  endtask
  // An empty FIFO at the null bit yields an all-zero result.
  task automatic run(input int k);
    logic [N-1:0] w;
    logic         e;
    logic [N-1:0] r;
    int           i;
    int           s;
    w = (q.size() > 0) ? q.pop_front() : '0;
    s = n_samp;
    host.frame(k);
    for (i = 0; i < k; i++) begin
      if (i < 2) e = 1'bz;
      else if (i == 2) e = 1'b0;
      else if (i < 3 + N) e = w[N + 2 - i];
      else if (i < 2 + 2 * N) e = w[i - 2 - N];
      else e = 1'b0;
      `CHK(host.got[i], e)
    end
    for (i = 0; i < N; i++) r[N - 1 - i] = host.got[3 + i];
    `CHK(r & 12'hff0, w & 12'hff0)
    `CHK(host.ana[2], 1'b1)
    if (k > 2 * N + 2) `CHK(host.ana[k - 1], 1'b0)
    @(negedge mclk);
    `CHK(digital_on, 1'b1)
    host.release_sel();
    @(negedge mclk);
    `CHK(dout_oe, 1'b0)
    `CHK(digital_on, 1'b0)
    `CHK(n_samp - s, 1)
  endtask
  initial begin
    void'($urandom(32'h5405_2a68));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    `CHK(dout_oe, 1'b0)
    `CHK(analog_on, 1'b0)
    `CHK(digital_on, 1'b0)
    `CHK(res_ready, 1'b1)
    $display("test reset done");
    foreach (codes[j]) push(codes[j]);
    repeat (4) push(N'($urandom_range(0, 4095)));
    @(negedge mclk);
    `CHK(res_ready, 1'b0)
    push(12'h5a5);
    `CHK(q.size(), 8)
    $display("test fill done");
    for (int i = 0; i < 8; i++) run((i % 2) ? 2 * N + 6 : N + 3);
    @(negedge mclk);
    `CHK(res_ready, 1'b1)
    $display("test drain done");
    run(N + 3);
    $display("test empty done");
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
